/* File: hw/pbd_pkg.sv */
// package: address map, config bit positions and timing for the peripheral bus decoder
package pbd_pkg;

  // ************************************************************
  // apb register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] PERIPH_CFG_OFFS = 12'h000;
  localparam logic [11:0] SYS_CFG_OFFS = 12'h004;
  localparam logic [11:0] STATUS_OFFS = 12'h008;
  localparam logic [15:0] PERIPH_CFG_RESET = 16'h0000;
  localparam logic [15:0] SYS_CFG_RESET = 16'h0000;

  // ************************************************************
  // peripheral_enable_config bit positions
  // ************************************************************
  localparam int BIT_CAN1 = 0;
  localparam int BIT_CAN2 = 1;
  localparam int BIT_XRAM_S = 2;
  localparam int BIT_XRAM_L = 3;
  localparam int BIT_RTC = 4;
  localparam int BIT_FLASH = 5;
  localparam int BIT_PWM = 6;
  localparam int BIT_ASC = 7;
  localparam int BIT_SSC = 8;
  localparam int BIT_I2C = 9;
  localparam int BIT_MISC = 10;

  // system_config bit positions
  localparam int BIT_GPB = 2;
  localparam int BIT_REMAP = 4;
  localparam int BIT_BOOT = 5;

  // ************************************************************
  // address map (24-bit linear space)
  // ************************************************************
  localparam logic [23:0] FCTRL_LO = 24'h0e0000;
  localparam logic [23:0] FCTRL_HI = 24'h0effff;
  localparam logic [23:0] XRAM_S_LO = 24'h00e000;
  localparam logic [23:0] XRAM_S_HI = 24'h00e7ff;
  localparam logic [23:0] XRAM_L_LO = 24'h0f0000;
  localparam logic [23:0] XRAM_L_HI = 24'h0f7fff;
  localparam logic [23:0] STBY_HI = 24'h0f3fff;
  localparam logic [23:0] TFLASH_LO = 24'h000000;
  localparam logic [23:0] TFLASH_HI = 24'h000fff;
  localparam logic [23:0] FL_LOW_LO = 24'h000000;
  localparam logic [23:0] FL_LOW_HI = 24'h007fff;
  localparam logic [23:0] FL_SEG1_LO = 24'h010000;
  localparam logic [23:0] FL_SEG1_HI = 24'h017fff;
  localparam logic [23:0] FL_B4_LO = 24'h018000;
  localparam logic [23:0] FL_HI = 24'h08ffff;
  localparam logic [23:0] FL_B5_LO = 24'h020000;

  // peripheral windows are 256 bytes; index by address bits [15:8] in segment 0
  localparam int NPER = 8;
  localparam logic [15:0] SEG0_HI_BITS = 16'h0000;
  typedef enum logic [2:0] {
    PBD_P_CAN1 = 3'h0, PBD_P_CAN2 = 3'h1, PBD_P_RTC = 3'h2, PBD_P_PWM = 3'h3,
    PBD_P_ASC = 3'h4, PBD_P_SSC = 3'h5, PBD_P_I2C = 3'h6, PBD_P_MISC = 3'h7
  } pbd_periph_e;
  localparam logic [7:0] WIN_PAGE [NPER] = '{8'hef, 8'hee, 8'hed, 8'hec, 8'he9, 8'he8, 8'hea, 8'heb};
  localparam int WIN_BIT [NPER] = '{BIT_CAN1, BIT_CAN2, BIT_RTC, BIT_PWM, BIT_ASC, BIT_SSC, BIT_I2C, BIT_MISC};

  // ************************************************************
  // target codes and timing
  // ************************************************************
  typedef enum logic [3:0] {
    PBD_T_EXT = 4'h0, PBD_T_FLASH = 4'h1, PBD_T_FCTRL = 4'h2, PBD_T_XRAM_S = 4'h3,
    PBD_T_XRAM_L = 4'h4, PBD_T_PERIPH = 4'h5
  } pbd_target_e;

  localparam int CLK_MHZ = 40;
  localparam int PER_ACCESS_NS = 100;
  localparam int RAM_ACCESS_NS = 50;
  localparam int CYC_NS = 1000 / CLK_MHZ;
  // access time minus the two-cycle base bus cycle gives the wait states
  localparam int PER_WAIT = (PER_ACCESS_NS + CYC_NS - 1) / CYC_NS - RAM_ACCESS_NS / CYC_NS;
  localparam int RAM_WAIT = 0;

endpackage : pbd_pkg

/* File: hw/pbd_decoder.sv */
// peripheral bus address decoder, access checking and clock gating
// ************************************************************
// ************************************************************
//
// The APB interface to the registers and the register offsets are this design's own decisions.
module pbd_decoder
  import pbd_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire logic end_of_init_instruction,
  input wire logic periph_reset_req,
  output logic [3:0] tgt_q,
  output logic [7:0] periph_sel_q,
  output logic [3:0] flash_block_q,
  output logic second_bank_alias_q,
  output logic test_flash_sel_q,
  output logic standby_ram_q,
  output logic [1:0] wait_states_q,
  output logic width_err_q,
  output logic prog_erase_allow,
  output logic [NPER-1:0] periph_clk_en,
  output logic [NPER-1:0] periph_reset,
  output logic [NPER-1:0] periph_visible
);

  // ************************************************************
  // elaboration check and local field positions
  // ************************************************************
  // segment and page fields are sliced at fixed bits, so only a 24-bit space can be served
  if (ADDR_W != 24) begin : g_bad_addr_w
    $error("pbd_decoder: address width must be 24");
  end

  localparam int CFG_W = 16;
  localparam int STAT_W = 1 + 4 + NPER;
  localparam int SEG_MSB = 23;
  localparam int SEG_LSB = 16;
  localparam int PAGE_MSB = 15;
  localparam int PAGE_LSB = 8;
  localparam int BLK_W = 4;
  // the four 8K blocks at the bottom of a segment are told apart by these two bits
  localparam int BLK8K_MSB = 14;
  localparam int BLK8K_LSB = 13;
  // upper flash: segment 1 holds the 32K block 4, each later segment one 64K block
  localparam logic [7:0] SEG_BLK4 = 8'h01;
  localparam logic [BLK_W-1:0] BLK_FOUR = 4'h4;
  localparam logic [BLK_W-1:0] SEG_TO_BLK = 4'h3;
  // the last two blocks carry the second-bank alias
  localparam logic [BLK_W-1:0] FIRST_ALIAS_BLK = 4'ha;

  // ************************************************************
  // apb registers
  // ************************************************************
  logic [15:0] peripheral_enable_config_q;
  logic [15:0] system_config_q;
  logic end_of_init_instruction_done_q;
  logic apb_wr;
  logic hit_pcfg, hit_scfg, hit_stat;

  assign hit_pcfg = paddr == PERIPH_CFG_OFFS;
  assign hit_scfg = paddr == SYS_CFG_OFFS;
  assign hit_stat = paddr == STATUS_OFFS;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  // unmapped addresses answer with an error, reads return zero
  assign pslverr = psel && penable && !(hit_pcfg || hit_scfg || hit_stat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_enable_config_q <= PERIPH_CFG_RESET;
    end else if (apb_wr && hit_pcfg) begin
      peripheral_enable_config_q <= pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_config_q <= SYS_CFG_RESET;
    end else if (apb_wr && hit_scfg) begin
      system_config_q <= pwdata[CFG_W-1:0];
    end
  end

  // end of init is a one-way latch until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_of_init_instruction_done_q <= 1'b0;
    end else if (end_of_init_instruction) begin
      end_of_init_instruction_done_q <= 1'b1;
    end
  end

  // read data is chosen in the setup cycle so it already stands when the access phase is sampled
  logic [31:0] rd_word;
  logic [31:0] status_word;

  assign status_word = {{(32 - STAT_W){1'b0}}, width_err_q, tgt_q, periph_sel_q};

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_pcfg) begin
      rd_word[CFG_W-1:0] = peripheral_enable_config_q;
    end
    if (hit_scfg) begin
      rd_word[CFG_W-1:0] = system_config_q;
    end
    if (hit_stat) begin
      rd_word = status_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // ************************************************************
  // enables
  // ************************************************************
  logic gpb_en, remap, boot_mode;
  logic xram_s_on, xram_l_on, fctrl_on;
  logic [NPER-1:0] per_en;

  assign gpb_en = system_config_q[BIT_GPB];
  assign remap = system_config_q[BIT_REMAP];
  assign boot_mode = system_config_q[BIT_BOOT];
  assign xram_s_on = gpb_en && peripheral_enable_config_q[BIT_XRAM_S];
  assign xram_l_on = gpb_en && peripheral_enable_config_q[BIT_XRAM_L];
  assign fctrl_on = peripheral_enable_config_q[BIT_FLASH];
  assign prog_erase_allow = fctrl_on;

  for (genvar i = 0; i < NPER; i++) begin : g_en
    // each window needs the global enable and its own bit
    assign per_en[i] = gpb_en && peripheral_enable_config_q[WIN_BIT[i]];
    assign periph_visible[i] = per_en[i];
  end

  // ************************************************************
  // clock gating and reset suppression
  // ************************************************************
  // the misc block stays clocked; rams have no gate here
  for (genvar i = 0; i < NPER; i++) begin : g_clk
    pbd_gate_ctl #(
      .FREE_RUN(i == PBD_P_MISC)
    ) u_gate (
      .end_of_init_instruction_done(end_of_init_instruction_done_q),
      .enabled(per_en[i]),
      .reset_req(periph_reset_req),
      .clk_en(periph_clk_en[i]),
      .reset_out(periph_reset[i])
    );
  end

  // ************************************************************
  // address decode
  // ************************************************************
  logic in_fctrl, in_xs, in_xl, in_tf, in_fl_low, in_fl_seg1, in_fl_hi;
  logic [NPER-1:0] win_hit;
  logic seg1_map;

  assign in_fctrl = acc_addr >= FCTRL_LO && acc_addr <= FCTRL_HI;
  assign in_xs = acc_addr >= XRAM_S_LO && acc_addr <= XRAM_S_HI;
  assign in_xl = acc_addr >= XRAM_L_LO && acc_addr <= XRAM_L_HI;
  assign in_tf = acc_addr <= TFLASH_HI;
  assign in_fl_low = acc_addr <= FL_LOW_HI;
  assign in_fl_seg1 = acc_addr >= FL_SEG1_LO && acc_addr <= FL_SEG1_HI;
  assign in_fl_hi = acc_addr >= FL_B4_LO && acc_addr <= FL_HI;
  assign seg1_map = remap || acc_write;

  for (genvar i = 0; i < NPER; i++) begin : g_win
    pbd_win_match #(
      .PAGE(WIN_PAGE[i])
    ) u_win (
      .seg(acc_addr[SEG_MSB:SEG_LSB]),
      .page(acc_addr[PAGE_MSB:PAGE_LSB]),
      .enable(per_en[i]),
      .hit(win_hit[i])
    );
  end

  // block numbers: bottom four 8K blocks by two address bits, upper blocks by segment number
  logic [3:0] lo_blk;
  logic [3:0] hi_blk;

  assign lo_blk = 4'(acc_addr[BLK8K_MSB:BLK8K_LSB]);

  always_comb begin
    hi_blk = 4'(acc_addr[SEG_LSB+BLK_W-1:SEG_LSB] + SEG_TO_BLK);
    if (acc_addr[SEG_MSB:SEG_LSB] == SEG_BLK4) begin
      hi_blk = BLK_FOUR;
    end
  end

  pbd_target_e tgt_d;
  logic [3:0] blk_d;
  logic tf_d;

  always_comb begin
    tgt_d = PBD_T_EXT;
    blk_d = 4'h0;
    tf_d = 1'b0;
    if (in_fctrl && fctrl_on) begin
      tgt_d = PBD_T_FCTRL;
    end else if (in_xs && xram_s_on) begin
      tgt_d = PBD_T_XRAM_S;
    end else if (in_xl && xram_l_on) begin
      tgt_d = PBD_T_XRAM_L;
    end else if (|win_hit) begin
      tgt_d = PBD_T_PERIPH;
    end else if (boot_mode && in_tf && !acc_write) begin
      tgt_d = PBD_T_FLASH;
      tf_d = 1'b1;
    end else if (!seg1_map && in_fl_low) begin
      tgt_d = PBD_T_FLASH;
      blk_d = lo_blk;
    end else if (seg1_map && in_fl_seg1) begin
      tgt_d = PBD_T_FLASH;
      blk_d = lo_blk;
    end else if (in_fl_hi) begin
      tgt_d = PBD_T_FLASH;
      blk_d = hi_blk;
    end
    // disabled ram ranges fall through to external, picking up its chip select
  end

  // ************************************************************
  // registered decode outputs
  // ************************************************************
  // each output keeps the last decode until the next request, so a bus cycle may use it throughout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_q <= PBD_T_EXT;
    end else if (acc_valid) begin
      tgt_q <= tgt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_sel_q <= 8'h00;
    end else if (acc_valid) begin
      periph_sel_q <= tgt_d == PBD_T_PERIPH ? win_hit : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_block_q <= 4'h0;
    end else if (acc_valid) begin
      flash_block_q <= blk_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_flash_sel_q <= 1'b0;
    end else if (acc_valid) begin
      test_flash_sel_q <= tf_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_bank_alias_q <= 1'b0;
    end else if (acc_valid) begin
      second_bank_alias_q <= tgt_d == PBD_T_FLASH && !tf_d && blk_d >= FIRST_ALIAS_BLK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_ram_q <= 1'b0;
    end else if (acc_valid) begin
      standby_ram_q <= tgt_d == PBD_T_XRAM_L && acc_addr <= STBY_HI;
    end
  end

  // rams and flash control take no wait state; peripherals take the two of their longer access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_states_q <= 2'h0;
    end else if (acc_valid) begin
      wait_states_q <= tgt_d == PBD_T_PERIPH ? 2'(PER_WAIT) : 2'(RAM_WAIT);
    end
  end

  // byte or word is fine everywhere except in the word-only peripheral windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_err_q <= 1'b0;
    end else if (acc_valid) begin
      width_err_q <= tgt_d == PBD_T_PERIPH && acc_byte;
    end
  end

endmodule : pbd_decoder

// ************************************************************
// one peripheral window: claims its 256-byte page of segment 0
// ************************************************************
module pbd_win_match
  import pbd_pkg::*;
#(
  parameter logic [7:0] PAGE = 8'h00
) (
  input wire logic [7:0] seg,
  input wire logic [7:0] page,
  input wire logic enable,
  output logic hit
);

  // the enable gates the match itself, so a disabled window never claims its page
  assign hit = enable && seg == SEG0_HI_BITS[7:0] && page == PAGE;

endmodule : pbd_win_match

// ************************************************************
// clock enable and reset pass for one peripheral
// ************************************************************
module pbd_gate_ctl #(
  parameter bit FREE_RUN = 1'b0
) (
  input wire logic end_of_init_instruction_done,
  input wire logic enabled,
  input wire logic reset_req,
  output logic clk_en,
  output logic reset_out
);

  if (FREE_RUN) begin : g_free
    assign clk_en = 1'b1;
  end else begin : g_gated
    // until end of init every peripheral runs, so software can set it up before it is frozen
    assign clk_en = !end_of_init_instruction_done || enabled;
  end

  // a stopped peripheral could not act on a reset; holding it back avoids a half-applied one
  assign reset_out = reset_req && clk_en;

endmodule : pbd_gate_ctl

/* File: verif/pbd_decoder_props.sv */
// checker: decode, width, wait and clock-gating relations at the decoder ports
module pbd_decoder_props
  import pbd_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_valid,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire logic end_of_init_instruction,
  input wire logic [3:0] tgt_q,
  input wire logic [7:0] periph_sel_q,
  input wire logic [3:0] flash_block_q,
  input wire logic second_bank_alias_q,
  input wire logic standby_ram_q,
  input wire logic [1:0] wait_states_q,
  input wire logic width_err_q,
  input wire logic prog_erase_allow,
  input wire logic [NPER-1:0] periph_clk_en,
  input wire logic [NPER-1:0] periph_reset,
  input wire logic [NPER-1:0] periph_visible
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************************
  // end-of-init tracker
  // ************************************************************
  logic eoi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eoi_q <= 1'b0;
    else if (end_of_init_instruction) eoi_q <= 1'b1;
  end
  fctrl_gate_a: assert property (acc_valid |=> (tgt_q == PBD_T_FCTRL) == ($past(prog_erase_allow) &&
    $past(acc_addr) inside {[FCTRL_LO:FCTRL_HI]})) else $error("flash control reach mismatch");
  per_wait_a: assert property (acc_valid |=> (tgt_q == PBD_T_PERIPH) == (wait_states_q == 2'h2))
    else $error("wait states mismatch");
  width_err_a: assert property (acc_valid |=> width_err_q == (tgt_q == PBD_T_PERIPH && $past(acc_byte)))
    else $error("width error mismatch");
  sel_visible_a: assert property (acc_valid |=> (periph_sel_q & ~$past(periph_visible)) == 8'h00)
    else $error("hidden window selected");
  standby_a: assert property (acc_valid |=> standby_ram_q == (tgt_q == PBD_T_XRAM_L && $past(acc_addr) <= STBY_HI))
    else $error("standby flag mismatch");
  small_ram_a: assert property (acc_valid ##1 tgt_q == PBD_T_XRAM_S |->
    $past(acc_addr) inside {[XRAM_S_LO:XRAM_S_HI]}) else $error("small ram outside range");
  flash_blk4_a: assert property (acc_valid && !acc_write && acc_addr inside {[FL_B4_LO:FL_B5_LO - 1]} |=>
    tgt_q == PBD_T_FLASH && flash_block_q == 4'h4) else $error("flash block 4 mismatch");
  bank_alias_a: assert property (acc_valid |=> second_bank_alias_q == (tgt_q == PBD_T_FLASH && flash_block_q >= 4'ha))
    else $error("bank alias mismatch");
  clk_ungated_a: assert property (!eoi_q |-> periph_clk_en == 8'hff) else $error("clock gated early");
  misc_clk_a: assert property (periph_clk_en[PBD_P_MISC]) else $error("misc clock stopped");
  gated_rst_a: assert property (eoi_q |-> (periph_reset & ~periph_clk_en) == 8'h00)
    else $error("reset to gated peripheral");
endmodule : pbd_decoder_props

bind pbd_decoder pbd_decoder_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_byte(acc_byte),
  .end_of_init_instruction(end_of_init_instruction), .tgt_q(tgt_q), .periph_sel_q(periph_sel_q),
  .flash_block_q(flash_block_q), .second_bank_alias_q(second_bank_alias_q), .standby_ram_q(standby_ram_q),
  .wait_states_q(wait_states_q), .width_err_q(width_err_q), .prog_erase_allow(prog_erase_allow),
  .periph_clk_en(periph_clk_en), .periph_reset(periph_reset), .periph_visible(periph_visible));

/* File: verif/pbd_cpu_model.sv */
// partner model: cpu side issuing one decode request per call
module pbd_cpu_model (
  input wire logic pclk,
  output logic acc_valid,
  output logic [23:0] acc_addr,
  output logic acc_write,
  output logic acc_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc_valid = 1'b0;
    acc_addr = 24'h000000;
    acc_write = 1'b0;
    acc_byte = 1'b0;
  end
  task automatic access(input logic [23:0] a, input logic wr, input logic byt);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_write <= wr;
    acc_byte <= byt;
    @(posedge pclk);
    // idle bus shows the inverse so a stale address never looks live
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_write <= ~wr;
    #1;
  endtask : access
endmodule : pbd_cpu_model

/* File: verif/pbd_decoder_test.sv */
// testbench: register access, address decode and clock gating of the decoder
module pbd_decoder_test
  import pbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic eoi = 1'b0;
  logic rst_req = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, acc_valid, acc_write, acc_byte, alias_q, tflash_q, stby_q, werr_q, pe_allow;
  logic [23:0] acc_addr;
  logic [3:0] tgt_q, blk_q;
  logic [7:0] sel_q, clk_en, p_rst, vis;
  logic [1:0] ws_q;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int waits = 0;
  always #12.5 pclk = ~pclk;
  pbd_cpu_model cpu (.pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_byte(acc_byte));
  pbd_decoder #(.ADDR_W(24)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_byte(acc_byte),
    .end_of_init_instruction(eoi), .periph_reset_req(rst_req), .tgt_q(tgt_q), .periph_sel_q(sel_q),
    .flash_block_q(blk_q), .second_bank_alias_q(alias_q), .test_flash_sel_q(tflash_q),
    .standby_ram_q(stby_q), .wait_states_q(ws_q), .width_err_q(werr_q), .prog_erase_allow(pe_allow),
    .periph_clk_en(clk_en), .periph_reset(p_rst), .periph_visible(vis));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    waits = -1;
    do begin
      @(posedge pclk);
      waits++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic dec(input logic [23:0] a, input logic wr, input logic byt, input logic [3:0] et);
    cpu.access(a, wr, byt);
    chk(tgt_q, et);
  endtask : dec
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    apb(1'b0, PERIPH_CFG_OFFS, 32'h0);
    chk(rd, PERIPH_CFG_RESET);
    chk(waits, 0);
    chk(err, 1'b0);
    apb(1'b0, SYS_CFG_OFFS, 32'h0);
    chk(rd, SYS_CFG_RESET);
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1);
    dec(24'h00e000, 1'b0, 1'b0, PBD_T_EXT);
    dec(24'h00ef00, 1'b0, 1'b0, PBD_T_EXT);
    dec(24'h0e0000, 1'b0, 1'b0, PBD_T_EXT);
    chk(pe_allow, 1'b0);
  endtask : t_regs
  task automatic t_on();
    apb(1'b1, PERIPH_CFG_OFFS, 32'h07ff);
    apb(1'b1, SYS_CFG_OFFS, 32'h0004);
    apb(1'b0, PERIPH_CFG_OFFS, 32'h0);
    chk(rd, 32'h0000_07ff);
    apb(1'b0, SYS_CFG_OFFS, 32'h0);
    chk(rd, 32'h0000_0004);
    for (int i = 0; i < NPER; i++) begin
      dec({8'h00, WIN_PAGE[i], 8'h10}, 1'b0, 1'b0, PBD_T_PERIPH);
      chk(sel_q, 8'h01 << i);
      chk(ws_q, 2'h2);
    end
    cpu.access(24'h00ef00, 1'b0, 1'b1);
    chk(werr_q, 1'b1);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk(rd, 32'h0000_1501);
    dec(24'h00e7ff, 1'b1, 1'b1, PBD_T_XRAM_S);
    chk({werr_q, ws_q}, 3'h0);
    dec(24'h0f3ffe, 1'b0, 1'b0, PBD_T_XRAM_L);
    chk(stby_q, 1'b1);
    dec(24'h0f4000, 1'b0, 1'b0, PBD_T_XRAM_L);
    chk(stby_q, 1'b0);
    dec(24'h0effff, 1'b1, 1'b1, PBD_T_FCTRL);
    chk({werr_q, pe_allow}, 2'h1);
    apb(1'b1, PERIPH_CFG_OFFS, 32'h07fe);
    dec(24'h00ef00, 1'b0, 1'b0, PBD_T_EXT);
    chk(vis[0], 1'b0);
    apb(1'b1, SYS_CFG_OFFS, 32'h0000);
    dec(24'h0f0000, 1'b0, 1'b0, PBD_T_EXT);
  endtask : t_on
  task automatic t_flash();
    dec(24'h018000, 1'b0, 1'b0, PBD_T_FLASH);
    chk(blk_q, 4'h4);
    dec(24'h08fffe, 1'b0, 1'b0, PBD_T_FLASH);
    chk({alias_q, blk_q}, 5'h1b);
    dec(24'h000000, 1'b0, 1'b0, PBD_T_FLASH);
    chk({tflash_q, blk_q}, 5'h00);
    dec(24'h010000, 1'b1, 1'b0, PBD_T_FLASH);
    apb(1'b1, SYS_CFG_OFFS, 32'h0020);
    cpu.access(24'h000000, 1'b0, 1'b0);
    chk(tflash_q, 1'b1);
    apb(1'b1, SYS_CFG_OFFS, 32'h0010);
    dec(24'h016000, 1'b0, 1'b0, PBD_T_FLASH);
    chk(blk_q, 4'h3);
  endtask : t_flash
  task automatic t_gate();
    apb(1'b1, PERIPH_CFG_OFFS, 32'h0001);
    apb(1'b1, SYS_CFG_OFFS, 32'h0004);
    chk(clk_en, 8'hff);
    eoi <= 1'b1;
    rst_req <= 1'b1;
    @(posedge pclk);
    eoi <= 1'b0;
    @(posedge pclk);
    #1;
    chk(clk_en, 8'h81);
    chk(p_rst, 8'h81);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(clk_en, 8'hff);
    apb(1'b0, PERIPH_CFG_OFFS, 32'h0);
    chk(rd, PERIPH_CFG_RESET);
  endtask : t_gate
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_on();
    t_flash();
    t_gate();
    wrap_up();
  end
endmodule : pbd_decoder_test
